// ---- design/pmc_defs.svh ----
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// Register byte offsets
`define PMC_OFS_MODE_CTRL 12'h000
`define PMC_OFS_ACT_TMPL 12'h004
`define PMC_OFS_ALT_TMPL 12'h008
`define PMC_OFS_STATUS 12'h00C
`define PMC_OFS_REG_CTRL 12'h010
`define PMC_OFS_WAKE_EN 12'h014
// Reset values
`define PMC_RST_ACT_TMPL 8'hFF
`define PMC_RST_ALT_TMPL 8'hFF
`define PMC_RST_REG_CTRL 2'h3
`define PMC_RST_WAKE_EN 8'hFF
// Field positions
`define PMC_CPU_BIT 0
`define PMC_FLASH_BIT 1
`define PMC_REQ_LSB 0
`define PMC_MODE_LSB 0
`define PMC_CPU_ST_BIT 4
// Buzz timing: interval and on-time in cycles of pclk
`define PMC_BUZZ_PERIOD 16'h0100
`define PMC_BUZZ_ON 16'h0008
`endif

// ---- design/pmc_pkg.sv ----
package pmc_pkg;
  // Global power modes in order of decreasing consumption
  typedef enum logic [1:0] {
    PMC_ACTIVE,
    PMC_ALT_ACTIVE,
    PMC_SLEEP,
    PMC_HIBERNATE
  } pmc_mode_e;
endpackage : pmc_pkg

// ---- design/pmc_top.sv ----
`include "pmc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pmc_top #(
  parameter int NSUB = 8,
  parameter int NWAKE = 8,
  parameter int PIN_SRC = 0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wakeup sources, asynchronous levels
  input wire logic [NWAKE-1:0] wake_irq,
  input wire logic dev_reset_evt,
  // Subsystem enables and clock gates
  output logic [NSUB-1:0] sub_enable,
  output logic [NSUB-1:0] sub_clk_en,
  // Low-speed and regulator controls
  output logic lowspeed_clk_en,
  output logic central_timewheel_run,
  output logic all_clk_stop,
  output logic state_retain,
  output logic dig_reg_en,
  output logic ana_reg_en,
  output logic [1:0] mode_out
);
  // Mode, template and control state
  pmc_pkg::pmc_mode_e mode_reg, mode_next;
  logic [NSUB-1:0] act_reg, act_next, alt_reg, alt_next;
  logic [NWAKE-1:0] wen_reg, wen_next;
  logic [1:0] regc_reg, regc_next;
  logic cpu_force_reg, cpu_force_next;
  logic [15:0] buzz_reg, buzz_next;

  // Synchroniser flops
  logic [NWAKE-1:0] wk_s1_reg, wk_s2_reg;
  logic rs_s1_reg, rs_s2_reg;

  // Decode and enable paths
  logic [NSUB-1:0] en_raw, en_comb;
  logic [31:0] rdata_next;
  logic wr, rd, hit, wake_any, wake_pin, buzz_on;
  logic wr_mode, wr_act, wr_alt, wr_regc, wr_wen;

  // Output next values
  logic [31:0] prdata_next;
  logic [NSUB-1:0] sub_enable_next, sub_clk_en_next;
  logic lowspeed_next, ctw_next, clk_stop_next, retain_next, dig_next, ana_next;
  logic [1:0] mode_out_next;

  function automatic logic ofs_hit(input logic [11:0] a);
    ofs_hit = (a == `PMC_OFS_MODE_CTRL) || (a == `PMC_OFS_ACT_TMPL) ||
      (a == `PMC_OFS_ALT_TMPL) || (a == `PMC_OFS_STATUS) ||
      (a == `PMC_OFS_REG_CTRL) || (a == `PMC_OFS_WAKE_EN);
  endfunction : ofs_hit

  function automatic logic is_hib(input pmc_pkg::pmc_mode_e m);
    is_hib = (m == pmc_pkg::PMC_HIBERNATE);
  endfunction : is_hib

  function automatic logic wr_to(input logic w, input logic [11:0] a, input logic [11:0] ofs);
    wr_to = w && (a == ofs);
  endfunction : wr_to

  // Input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_s1_reg <= '0;
      wk_s2_reg <= '0;
      rs_s1_reg <= 1'b0;
      rs_s2_reg <= 1'b0;
    end else begin
      wk_s1_reg <= wake_irq;
      wk_s2_reg <= wk_s1_reg;
      rs_s1_reg <= dev_reset_evt;
      rs_s2_reg <= rs_s1_reg;
    end
  end

  // Bus decode
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign hit = ofs_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_mode = wr_to(wr, paddr, `PMC_OFS_MODE_CTRL);
  assign wr_act = wr_to(wr, paddr, `PMC_OFS_ACT_TMPL);
  assign wr_alt = wr_to(wr, paddr, `PMC_OFS_ALT_TMPL);
  assign wr_regc = wr_to(wr, paddr, `PMC_OFS_REG_CTRL);
  assign wr_wen = wr_to(wr, paddr, `PMC_OFS_WAKE_EN);
  // Enabled interrupt or device reset is a wakeup
  assign wake_any = (|(wk_s2_reg & wen_reg)) || rs_s2_reg;
  // Only the pin interrupt source or a device reset wakes from hibernate
  assign wake_pin = (wk_s2_reg[PIN_SRC] && wen_reg[PIN_SRC]) || rs_s2_reg;

  // Template and regulator control registers
  always_comb begin
    act_next = act_reg;
    alt_next = alt_reg;
    wen_next = wen_reg;
    regc_next = regc_reg;
    if (wr_act) begin
      act_next = pwdata[NSUB-1:0];
    end
    if (wr_alt) begin
      alt_next = pwdata[NSUB-1:0];
    end
    if (wr_wen) begin
      wen_next = pwdata[NWAKE-1:0];
    end
    if (wr_regc) begin
      regc_next = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= NSUB'(`PMC_RST_ACT_TMPL);
      alt_reg <= NSUB'(`PMC_RST_ALT_TMPL);
      wen_reg <= NWAKE'(`PMC_RST_WAKE_EN);
      regc_reg <= `PMC_RST_REG_CTRL;
    end else begin
      act_reg <= act_next;
      alt_reg <= alt_next;
      wen_reg <= wen_next;
      regc_reg <= regc_next;
    end
  end

  // Mode and CPU force
  always_comb begin
    mode_next = mode_reg;
    cpu_force_next = cpu_force_reg;
    if (wr_mode) begin
      mode_next = pmc_pkg::pmc_mode_e'(pwdata[`PMC_REQ_LSB +: 2]);
      if (pwdata[`PMC_REQ_LSB +: 2] != 2'h0) begin
        cpu_force_next = 1'b0;
      end
    end
    if ((wr_act || wr_alt) && !pwdata[`PMC_CPU_BIT]) begin
      cpu_force_next = 1'b0;
    end
    // Wakeup wins over any write in the same cycle
    case (mode_reg)
      pmc_pkg::PMC_HIBERNATE: begin
        if (wake_pin) begin
          mode_next = pmc_pkg::PMC_ACTIVE;
          cpu_force_next = 1'b1;
        end
      end
      default: begin
        if (wake_any) begin
          mode_next = pmc_pkg::PMC_ACTIVE;
          cpu_force_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= pmc_pkg::PMC_ACTIVE;
      cpu_force_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cpu_force_reg <= cpu_force_next;
    end
  end

  // Regulator buzz timer, runs only in sleep
  always_comb begin
    buzz_next = 16'h0000;
    if (mode_reg == pmc_pkg::PMC_SLEEP) begin
      buzz_next = (buzz_reg == `PMC_BUZZ_PERIOD - 16'h0001) ? 16'h0000 :
        buzz_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzz_reg <= 16'h0000;
    end else begin
      buzz_reg <= buzz_next;
    end
  end

  assign buzz_on = buzz_reg < `PMC_BUZZ_ON;

  // Subsystem enables per mode
  always_comb begin
    case (mode_reg)
      pmc_pkg::PMC_ACTIVE: en_raw = act_reg;
      pmc_pkg::PMC_ALT_ACTIVE: en_raw = alt_reg;
      default: en_raw = '0;
    endcase
    en_comb = en_raw;
    if (cpu_force_reg && (mode_reg == pmc_pkg::PMC_ACTIVE)) begin
      en_comb[`PMC_CPU_BIT] = 1'b1;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `PMC_OFS_MODE_CTRL: rdata_next[`PMC_MODE_LSB +: 2] = mode_reg;
      `PMC_OFS_ACT_TMPL: rdata_next[NSUB-1:0] = act_reg;
      `PMC_OFS_ALT_TMPL: rdata_next[NSUB-1:0] = alt_reg;
      `PMC_OFS_STATUS: begin
        rdata_next[`PMC_MODE_LSB +: 2] = mode_reg;
        rdata_next[`PMC_CPU_ST_BIT] = en_comb[`PMC_CPU_BIT];
      end
      `PMC_OFS_REG_CTRL: rdata_next[1:0] = regc_reg;
      `PMC_OFS_WAKE_EN: rdata_next[NWAKE-1:0] = wen_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Output next values
  always_comb begin
    prdata_next = prdata;
    if (psel && !penable && !pwrite) begin
      prdata_next = rdata_next;
    end
    sub_enable_next = en_comb;
    sub_clk_en_next = en_comb;
    lowspeed_next = !is_hib(mode_reg);
    ctw_next = !is_hib(mode_reg);
    clk_stop_next = is_hib(mode_reg);
    retain_next = is_hib(mode_reg);
    case (mode_reg)
      pmc_pkg::PMC_SLEEP: begin
        dig_next = regc_reg[0] && buzz_on;
        ana_next = regc_reg[1] && buzz_on;
      end
      pmc_pkg::PMC_HIBERNATE: begin
        dig_next = 1'b0;
        ana_next = 1'b0;
      end
      default: begin
        dig_next = regc_reg[0];
        ana_next = regc_reg[1];
      end
    endcase
    mode_out_next = mode_reg;
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      sub_enable <= '0;
      sub_clk_en <= '0;
      lowspeed_clk_en <= 1'b1;
      central_timewheel_run <= 1'b1;
      all_clk_stop <= 1'b0;
      state_retain <= 1'b0;
      dig_reg_en <= 1'b1;
      ana_reg_en <= 1'b1;
      mode_out <= 2'h0;
    end else begin
      prdata <= prdata_next;
      sub_enable <= sub_enable_next;
      sub_clk_en <= sub_clk_en_next;
      lowspeed_clk_en <= lowspeed_next;
      central_timewheel_run <= ctw_next;
      all_clk_stop <= clk_stop_next;
      state_retain <= retain_next;
      dig_reg_en <= dig_next;
      ana_reg_en <= ana_next;
      mode_out <= mode_out_next;
    end
  end

  logic unused_rd;
  assign unused_rd = rd;
endmodule : pmc_top
`default_nettype wire

// ---- verif/pmc_wake_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmc_wake_src (
  // Clock
  input wire logic pclk,
  // Wake sources
  output logic [7:0] wake_irq,
  output logic dev_reset_evt
);
  initial {dev_reset_evt, wake_irq} = 9'h000;
  // Sets the wake levels, reset event on top
  task put(input logic [8:0] v);
    @(posedge pclk);
    {dev_reset_evt, wake_irq} <= v;
  endtask : put
  // Pulse held n cycles, short or long
  task fire(input logic [8:0] v, input int n);
    put(v);
    repeat (n) @(posedge pclk);
    {dev_reset_evt, wake_irq} <= 9'h000;
  endtask : fire
endmodule : pmc_wake_src
`default_nettype wire

// ---- verif/pmc_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_top_chk #(
  parameter int NSUB = 8,
  parameter int NWAKE = 8
) (
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Wake sources
  input wire logic [NWAKE-1:0] wake_irq,
  input wire logic dev_reset_evt,
  // Controls
  input wire logic [NSUB-1:0] sub_enable,
  input wire logic [NSUB-1:0] sub_clk_en,
  input wire logic lowspeed_clk_en,
  input wire logic central_timewheel_run,
  input wire logic all_clk_stop,
  input wire logic state_retain,
  input wire logic dig_reg_en,
  input wire logic ana_reg_en,
  input wire logic [1:0] mode_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  gate_clk_a: assert property ((sub_clk_en & ~sub_enable) == '0)
    else $error("clock on while disabled");
  boot_mode_a: assert property ($rose(presetn) |-> mode_out == 2'h0)
    else $error("mode after reset");
  sleep_off_a: assert property (mode_out == 2'h2 |-> sub_enable[1:0] == 2'h0
    && central_timewheel_run) else $error("sleep resources");
  hib_stop_a: assert property (mode_out == 2'h3 |-> all_clk_stop && state_retain
    && sub_clk_en == '0) else $error("hibernate clocks");
  hib_reg_a: assert property (mode_out == 2'h3 |-> !dig_reg_en && !ana_reg_en
    && !lowspeed_clk_en) else $error("hibernate regulators");
  run_clk_a: assert property (mode_out != 2'h3 |-> !all_clk_stop && lowspeed_clk_en)
    else $error("clocks stopped");
  wake_rst_a: assert property ($rose(dev_reset_evt) |-> ##[1:6] mode_out == 2'h0
    && sub_enable[0]) else $error("reset wake");
  tmpl_dyn_a: assert property (psel && penable && pwrite && paddr == `PMC_OFS_ACT_TMPL
    && mode_out == 2'h0 && wake_irq == '0 && !dev_reset_evt |-> ##2
    sub_enable[NSUB-1:1] == $past(pwdata[NSUB-1:1], 2)) else $error("template");
  sleep_req_a: assert property (psel && penable && pwrite && paddr == `PMC_OFS_MODE_CTRL
    && pwdata[1:0] == 2'h2 && mode_out == 2'h0 && wake_irq == '0 && !dev_reset_evt
    |-> ##2 mode_out == 2'h2) else $error("sleep entry");
endmodule : pmc_top_chk
bind pmc_top pmc_top_chk #(.NSUB(NSUB), .NWAKE(NWAKE)) u_chk (.*);
`default_nettype wire

// ---- verif/power_mode_controller_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module power_mode_controller_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, se, lowspeed_clk_en, central_timewheel_run, all_clk_stop;
  logic state_retain, dig_reg_en, ana_reg_en, dev_reset_evt;
  logic [7:0] wake_irq, sub_enable, sub_clk_en, act, alt;
  logic [1:0] mode_out;
  int err_total = 0, n_compared = 0, cycles = 0, cnt;
  integer seed = 32'h23c68271;
  always #20 pclk = ~pclk;
  pmc_top DUT (.*);
  pmc_wake_src W (.*);
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function logic [7:0] exp_sub(input logic [1:0] m, input logic [7:0] a, input logic [7:0] b);
    return m == 2'h0 ? a : m == 2'h1 ? b : 8'h00;
  endfunction : exp_sub
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    `CHK({mode_out, dig_reg_en, ana_reg_en, sub_enable}, 12'h3FF)
    for (int i = 0; i < 8; i++) begin
      act = (i == 0) ? 8'h00 : $random(seed);
      apb(1'b1, `PMC_OFS_ACT_TMPL, {24'h0, act});
      cyc(2);
      `CHK({sub_clk_en, sub_enable}, {2{exp_sub(2'h0, act, 8'h0)}})
    end
    act = 8'hFE;
    apb(1'b1, `PMC_OFS_ACT_TMPL, {24'h0, act});
    cyc(2);
    `CHK(sub_enable[0], 1'b0)
    W.fire(9'h008, 2);
    cyc(5);
    `CHK(sub_enable, 8'hFF)
    $display("test templates done");
    for (int m = 1; m < 4; m++) begin
      alt = $random(seed) & 8'hFC;
      apb(1'b1, `PMC_OFS_ALT_TMPL, {24'h0, alt});
      apb(1'b1, `PMC_OFS_MODE_CTRL, m);
      cyc(3);
      apb(1'b0, `PMC_OFS_STATUS, 0);
      `CHK({rd[1:0], mode_out, sub_enable}, {m[1:0], m[1:0], exp_sub(m[1:0], act, alt)})
      `CHK({all_clk_stop, state_retain, lowspeed_clk_en}, (m == 3) ? 3'b110 : 3'b001)
      cnt = 0;
      repeat (256) begin
        cyc(1);
        cnt += dig_reg_en;
      end
      if (m == 2) `CHK(cnt > 0 && cnt < 256, 1'b1)
      W.fire(9'h002, 6);
      cyc(4);
      `CHK(mode_out, (m == 3) ? 2'h3 : 2'h0)
      W.fire(9'h001, 2);
      cyc(5);
      `CHK({mode_out, sub_enable[0]}, 3'h1)
    end
    $display("test modes done");
    apb(1'b1, `PMC_OFS_MODE_CTRL, 2);
    cyc(3);
    W.fire(9'h100, 2);
    cyc(5);
    `CHK(mode_out, 2'h0)
    W.put(9'h004);
    cyc(4);
    apb(1'b1, `PMC_OFS_MODE_CTRL, 2);
    cyc(4);
    `CHK(mode_out, 2'h0)
    W.put(9'h000);
    apb(1'b1, `PMC_OFS_REG_CTRL, 0);
    apb(1'b0, 12'h018, 0);
    cyc(2);
    `CHK({se, rd, dig_reg_en, ana_reg_en}, {1'b1, 32'h0, 2'b00})
    $display("test wakeups done");
    close_out;
  end
endmodule : power_mode_controller_tb
`default_nettype wire
